// [verilog/ddrrp_pkg.sv]
package ddrrp_pkg;
  // command codes: {cs, ras, cas, we}
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_MRS = 4'h0;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam int NUM_BANKS = 4;
  localparam int BANK_W = 2;
  localparam int ROW_W = 13;
  localparam int AP_BIT = 10;
  localparam int BURST_LEN = 4;
  localparam logic [1:0] BURST_CYC = 2'h1;
  localparam logic [ROW_W-1:0] ROW_RST = 13'h0000;

  typedef enum logic [2:0] {
    DDRRP_IDLE = 3'b000,
    DDRRP_ACTIVE = 3'b001,
    DDRRP_PRE_PD = 3'b010,
    DDRRP_ACT_PD = 3'b011,
    DDRRP_SELF_REF = 3'b100,
    DDRRP_ILLEGAL = 3'b101
  } ddrrp_state_t;
endpackage : ddrrp_pkg

// [verilog/ddrrp_cmd.sv]
`timescale 1ns/1ps
// Operation
// - cs, ras, cas low, we high with clock gate high twice: refresh
// - refresh row and bank come from the internal counter
// - clock gate low with nop or deselect enters power-down
// - all banks idle: precharge power-down, else active power-down
// - power-down disables buffers except clock, termination and gate
// - loop off in precharge and slow-exit active power-down
// - gate high with nop or deselect exits power-down, then latency
// - command decode from cs, ras, cas, we and clock gate
// - bank bits choose bank, or mode register for mode set
// - bursts of four always complete, never interrupted
// - refresh with gate falling enters self refresh, exit as from power-down
// - no internal refresh during power-down
// - bit ten selects auto-precharge or all-bank precharge
module ddrrp_cmd #(
  parameter bit FAST_EXIT = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic linkClk,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic clkGate,
  input wire logic [ddrrp_pkg::BANK_W-1:0] bankSel,
  input wire logic [ddrrp_pkg::ROW_W-1:0] addr,
  input wire logic termination_ctl,
  output logic [ddrrp_pkg::NUM_BANKS-1:0] bankOpen,
  output logic [2:0] pdState,
  output logic dllOn,
  output logic buffersOn,
  output logic refreshPulse,
  output logic [ddrrp_pkg::BANK_W-1:0] refreshBank,
  output logic [ddrrp_pkg::ROW_W-1:0] refreshRow,
  output logic modeSetPulse,
  output logic [ddrrp_pkg::BANK_W-1:0] modeSetSel,
  output logic [ddrrp_pkg::ROW_W-1:0] modeSetOp,
  output logic burstBusy,
  output logic illegalSeq,
  output logic terminationOn
);
  // link side: sample pins on link clock, fold deselect into nop; decode on the core side
  logic [3:0] cmdL;
  logic gateL, gatePrevL;
  logic [ddrrp_pkg::BANK_W-1:0] bankL;
  logic [ddrrp_pkg::ROW_W-1:0] addrL;
  logic evToggle;
  logic [ddrrp_pkg::BANK_W+ddrrp_pkg::ROW_W+5:0] evWord;

  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      cmdL <= ddrrp_pkg::CMD_NOP;
      gateL <= 1'b0;
      gatePrevL <= 1'b0;
      bankL <= '0;
      addrL <= ddrrp_pkg::ROW_RST;
    end else begin
      cmdL <= csN ? ddrrp_pkg::CMD_NOP : {csN, rasN, casN, weN};
      gateL <= clkGate;
      gatePrevL <= gateL;
      bankL <= bankSel;
      addrL <= addr;
    end
  end

  // each link edge is one event; word held stable while toggle crosses
  always_ff @(posedge linkClk or posedge rst) begin
    if (rst) begin
      evToggle <= 1'b0;
      evWord <= '0;
    end else begin
      evToggle <= ~evToggle;
      evWord <= {gatePrevL, gateL, cmdL, bankL, addrL};
    end
  end

  // core side: toggle sync; word sampled two stages later, already stable
  logic tgS1, tgS2, tgS3;
  logic [ddrrp_pkg::BANK_W+ddrrp_pkg::ROW_W+5:0] wordC;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      tgS1 <= 1'b0;
      tgS2 <= 1'b0;
      tgS3 <= 1'b0;
    end else begin
      tgS1 <= evToggle;
      tgS2 <= tgS1;
      tgS3 <= tgS2;
    end
  end
  // a toggle edge marks one link event; wordC is taken one clock after
  // tgS2 settles, still inside the link period the word is held for
  wire evEdge = tgS2 != tgS3;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wordC <= '0;
    end else if (evEdge) begin
      wordC <= evWord;
    end
  end

  logic evValid;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      evValid <= 1'b0;
    end else begin
      evValid <= evEdge;
    end
  end

  wire gPrev = wordC[ddrrp_pkg::BANK_W+ddrrp_pkg::ROW_W+5];
  wire gNow = wordC[ddrrp_pkg::BANK_W+ddrrp_pkg::ROW_W+4];
  wire [3:0] cmd = wordC[ddrrp_pkg::BANK_W+ddrrp_pkg::ROW_W+3 -:4];
  wire [ddrrp_pkg::BANK_W-1:0] bankC = wordC[ddrrp_pkg::ROW_W +:
    ddrrp_pkg::BANK_W];
  wire [ddrrp_pkg::ROW_W-1:0] addrC = wordC[ddrrp_pkg::ROW_W-1:0];
  wire apBit = addrC[ddrrp_pkg::AP_BIT];

  wire isNop = cmd == ddrrp_pkg::CMD_NOP;
  wire isRef = cmd == ddrrp_pkg::CMD_REF;
  wire bothHigh = gPrev && gNow;
  wire fall = gPrev && !gNow;
  wire rise = !gPrev && gNow;
  wire allIdle = bankOpen == '0;
  ddrrp_pkg::ddrrp_state_t state, next_state;
  wire inPd = state == ddrrp_pkg::DDRRP_PRE_PD ||
    state == ddrrp_pkg::DDRRP_ACT_PD || state == ddrrp_pkg::DDRRP_SELF_REF;
  wire running = !inPd && state != ddrrp_pkg::DDRRP_ILLEGAL;

  wire doRef = evValid && running && bothHigh && isRef && allIdle;
  wire doSelf = evValid && running && fall && isRef && allIdle;
  wire doPd = evValid && running && fall && isNop;
  wire doExit = evValid && inPd && rise && isNop;
  wire doIllegal = evValid && running && fall && !isNop && !isRef;
  wire doCmd = evValid && running && bothHigh;
  wire isAct = cmd == ddrrp_pkg::CMD_ACT;
  wire isPre = cmd == ddrrp_pkg::CMD_PRE;
  wire isRw = cmd == ddrrp_pkg::CMD_RD || cmd == ddrrp_pkg::CMD_WR;
  wire isMrs = cmd == ddrrp_pkg::CMD_MRS;

  wire doAct = doCmd && isAct;
  wire doPre = doCmd && isPre;
  // a read or write inside a running burst is dropped, not queued
  wire doRw = doCmd && !burstBusy && isRw;
  // mode set with a row open is ignored rather than flagged
  wire doMrs = doCmd && isMrs && allIdle;

  always_comb begin
    next_state = state;
    unique case (state)
      ddrrp_pkg::DDRRP_IDLE, ddrrp_pkg::DDRRP_ACTIVE: begin
        if (doIllegal) next_state = ddrrp_pkg::DDRRP_ILLEGAL;
        else if (doSelf) next_state = ddrrp_pkg::DDRRP_SELF_REF;
        else if (doPd) next_state = allIdle ? ddrrp_pkg::DDRRP_PRE_PD :
          ddrrp_pkg::DDRRP_ACT_PD;
        else next_state = allIdle ? ddrrp_pkg::DDRRP_IDLE :
          ddrrp_pkg::DDRRP_ACTIVE;
      end
      ddrrp_pkg::DDRRP_PRE_PD, ddrrp_pkg::DDRRP_ACT_PD,
      ddrrp_pkg::DDRRP_SELF_REF: begin
        if (doExit) next_state = allIdle ? ddrrp_pkg::DDRRP_IDLE :
          ddrrp_pkg::DDRRP_ACTIVE;
      end
      ddrrp_pkg::DDRRP_ILLEGAL: next_state = ddrrp_pkg::DDRRP_ILLEGAL;
      default: next_state = ddrrp_pkg::DDRRP_ILLEGAL;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= ddrrp_pkg::DDRRP_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // bank tracking; auto-precharge closes the bank once the burst count reaches zero, before busy drops
  logic apPending;
  logic [ddrrp_pkg::BANK_W-1:0] apBank;
  logic [1:0] burstCnt;
  wire burstDone = burstBusy && burstCnt == '0;
  logic [ddrrp_pkg::NUM_BANKS-1:0] next_bankOpen;
  genvar b;
  generate
    for (b = 0; b < ddrrp_pkg::NUM_BANKS; b++) begin : g_bank
      localparam int BW = ddrrp_pkg::BANK_W;
      wire [BW-1:0] bankId = BW'(b);
      wire hit = bankC == bankId;
      // level stays true until the next event; clearing twice is harmless
      wire closeAp = burstDone && apPending && apBank == bankId;
      wire closePre = doPre && (apBit || hit);
      assign next_bankOpen[b] = (doAct && hit) ? 1'b1 :
        (closeAp || closePre) ? 1'b0 : bankOpen[b];
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bankOpen <= '0;
    end else begin
      bankOpen <= next_bankOpen;
    end
  end

  // bursts run to completion; read or write during a burst is dropped
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      burstBusy <= 1'b0;
      burstCnt <= '0;
      apPending <= 1'b0;
      apBank <= '0;
    end else if (doRw) begin
      burstBusy <= 1'b1;
      burstCnt <= ddrrp_pkg::BURST_CYC;
      apPending <= apBit;
      apBank <= bankC;
    end else if (burstBusy && evValid) begin
      burstCnt <= burstCnt - 2'h1;
      burstBusy <= burstCnt != '0;
      if (burstDone) apPending <= 1'b0;
    end
  end

  // internal refresh counter; stalls in power-down
  logic [ddrrp_pkg::BANK_W+ddrrp_pkg::ROW_W-1:0] refCnt;
  // doRef needs a running state, so power-down never advances it
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refCnt <= '0;
    end else if (doRef) begin
      refCnt <= refCnt + 1'b1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refreshPulse <= 1'b0;
    end else begin
      refreshPulse <= doRef;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      refreshBank <= '0;
      refreshRow <= ddrrp_pkg::ROW_RST;
    end else if (doRef) begin
      refreshBank <= refCnt[ddrrp_pkg::BANK_W-1:0];
      refreshRow <= refCnt[ddrrp_pkg::BANK_W +: ddrrp_pkg::ROW_W];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeSetPulse <= 1'b0;
    end else begin
      modeSetPulse <= doMrs;
    end
  end

  // bank bits pick the target register, address bits carry its value
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeSetSel <= '0;
      modeSetOp <= ddrrp_pkg::ROW_RST;
    end else if (doMrs) begin
      modeSetSel <= bankC;
      modeSetOp <= addrC;
    end
  end

  wire loopOff = state == ddrrp_pkg::DDRRP_PRE_PD ||
    state == ddrrp_pkg::DDRRP_SELF_REF ||
    (state == ddrrp_pkg::DDRRP_ACT_PD && !FAST_EXIT);

  logic termS1, termS2;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      termS1 <= 1'b0;
      termS2 <= 1'b0;
    end else begin
      termS1 <= termination_ctl;
      termS2 <= termS1;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pdState <= ddrrp_pkg::DDRRP_IDLE;
    end else begin
      pdState <= state;
    end
  end

  // the loop status trails the state by one clock, like pdState
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dllOn <= 1'b1;
    end else begin
      dllOn <= !loopOff;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      buffersOn <= 1'b1;
    end else begin
      buffersOn <= !inPd;
    end
  end

  // sticky: only a reset leaves the illegal state
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      illegalSeq <= 1'b0;
    end else begin
      illegalSeq <= state == ddrrp_pkg::DDRRP_ILLEGAL;
    end
  end

  // termination is not offered while self refresh runs
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      terminationOn <= 1'b0;
    end else begin
      terminationOn <= termS2 && state != ddrrp_pkg::DDRRP_SELF_REF;
    end
  end
endmodule : ddrrp_cmd

// [tb/ddrrp_cmd_checker.sv]
`timescale 1ns/1ps
module ddrrp_cmd_checker #(
  parameter bit FAST_EXIT = 1'b1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [3:0] bankOpen,
  input wire logic [2:0] pdState,
  input wire logic dllOn,
  input wire logic buffersOn,
  input wire logic refreshPulse,
  input wire logic burstBusy,
  input wire logic illegalSeq
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  AST_REF_ONE: assert property (refreshPulse |=> !refreshPulse)
    else $error("refresh pulse too long");
  AST_PPD: assert property (pdState == 3'h2 |-> bankOpen == 4'h0)
    else $error("precharge power-down with open bank");
  AST_APD: assert property (pdState == 3'h3 |-> bankOpen != 4'h0)
    else $error("active power-down with no open bank");
  AST_DLL_OFF: assert property (
    pdState inside {3'h2, 3'h4} |-> !dllOn) else $error("dll left on");
  AST_DLL_FAST: assert property (
    pdState == 3'h3 |-> dllOn == FAST_EXIT) else $error("dll wrong");
  AST_BUF: assert property (
    pdState inside {3'h2, 3'h3} |-> !buffersOn) else $error("buffers on");
  AST_NO_REF: assert property (
    pdState inside {3'h2, 3'h3} |-> !refreshPulse) else $error("refresh");
  AST_BURST: assert property ($rose(burstBusy) |-> burstBusy[*4])
    else $error("burst cut short");
  AST_ILL: assert property (illegalSeq |=> illegalSeq)
    else $error("illegal flag dropped");
endmodule : ddrrp_cmd_checker
bind ddrrp_cmd ddrrp_cmd_checker #(.FAST_EXIT(FAST_EXIT))
  ddrrp_cmd_checker_i (.*);

// [tb/ddrrp_ctl_model.sv]
`timescale 1ns/1ps
module ddrrp_ctl_model (
  input wire logic linkClk,
  output logic csN,
  output logic rasN,
  output logic casN,
  output logic weN,
  output logic clkGate,
  output logic [1:0] bankSel,
  output logic [12:0] addr,
  output logic termination_ctl
);
  initial begin
    {csN, rasN, casN, weN} = 4'hf;
    clkGate = 1'b1;
    bankSel = 2'h0;
    addr = 13'h0000;
    termination_ctl = 1'b0; // off and valid
  end
  // deselects follow with the don't-care pins flipped, so stale values
  // cannot help; a new gate level is held three edges
  task issue(input logic [3:0] c, input logic g, input logic [1:0] b,
    input logic [12:0] a);
    int n;
    n = (g !== clkGate) ? 3 : 1;
    @(posedge linkClk);
    {csN, rasN, casN, weN} <= c;
    clkGate <= g;
    bankSel <= b;
    addr <= a;
    repeat (n) begin
      @(posedge linkClk);
      {csN, rasN, casN, weN} <= {1'b1, ~c[2:0]};
      bankSel <= ~b;
      addr <= ~a;
    end
  endtask : issue
endmodule : ddrrp_ctl_model

// [tb/testbench.sv]
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic rst;
  logic linkClk = 1'b0;
  logic csN, rasN, casN, weN, clkGate, termination_ctl, dllOn, buffersOn;
  logic refreshPulse, modeSetPulse, burstBusy, illegalSeq, terminationOn;
  logic [1:0] bankSel, refreshBank, modeSetSel;
  logic [12:0] addr, refreshRow, modeSetOp;
  logic [3:0] bankOpen;
  logic [2:0] pdState;
  int failures = 0;
  int compares = 0;
  int cycles = 0;
  int refPulses = 0;
  int modePulses = 0;
  always @(posedge clk) begin
    if (refreshPulse === 1'b1) refPulses <= refPulses + 1;
    if (modeSetPulse === 1'b1) modePulses <= modePulses + 1;
  end
  ddrrp_cmd #(.FAST_EXIT(1'b1)) ddrrp_cmd_i (.*);
  ddrrp_ctl_model ddrrp_ctl_model_i (.*);
  always #2 clk = ~clk;
  initial begin
    #1.3;
    forever #7.5 linkClk = ~linkClk;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      failures++;
      end_sim();
    end
  end
  task check(input string name, input logic [15:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task end_sim();
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : end_sim
  // a burst ends three link edges after the command edge, 20 covers it
  task cmd(input logic [3:0] c, input logic g, input logic [1:0] b,
    input logic [12:0] a);
    ddrrp_ctl_model_i.issue(c, g, b, a);
    repeat (20) @(posedge clk);
    #1;
  endtask : cmd
  task t_refresh_mode();
    // refreshes come far inside the retention window
    cmd(ddrrp_pkg::CMD_REF, 1'b1, 2'h0, 13'h0000);
    check("ref bank", 16'(refreshBank), 16'h0);
    check("ref pulses", 16'(refPulses), 16'h1);
    cmd(ddrrp_pkg::CMD_REF, 1'b1, 2'h3, 13'h1fff);
    check("ref bank", 16'(refreshBank), 16'h1);
    check("ref row", 16'(refreshRow), 16'h0);
    check("ref pulses", 16'(refPulses), 16'h2);
    cmd(ddrrp_pkg::CMD_MRS, 1'b1, 2'h2, 13'h0123);
    check("mode sel", 16'(modeSetSel), 16'h2);
    check("mode op", 16'(modeSetOp), 16'h0123);
    $display("refresh test done");
  endtask : t_refresh_mode
  task t_power_down();
    cmd(ddrrp_pkg::CMD_ACT, 1'b1, 2'h2, 13'h0055);
    check("open", 16'(bankOpen), 16'h4);
    // gate drops with a row open, loop locked
    cmd(ddrrp_pkg::CMD_NOP, 1'b0, 2'h0, 13'h0000);
    check("state", 16'(pdState), 16'h3);
    check("term", 16'(terminationOn), 16'h0);
    check("dll", 16'(dllOn), 16'h1);
    check("buffers", 16'(buffersOn), 16'h0);
    cmd(ddrrp_pkg::CMD_NOP, 1'b1, 2'h0, 13'h0000);
    check("state", 16'(pdState), 16'h1);
    // gate stays high until the burst has run out
    cmd(ddrrp_pkg::CMD_RD, 1'b1, 2'h2, 13'h0400);
    check("open", 16'(bankOpen), 16'h0);
    cmd(ddrrp_pkg::CMD_ACT, 1'b1, 2'h1, 13'h0000);
    cmd(ddrrp_pkg::CMD_PRE, 1'b1, 2'h0, 13'h0400);
    check("open", 16'(bankOpen), 16'h0);
    cmd(ddrrp_pkg::CMD_NOP, 1'b0, 2'h0, 13'h0000);
    check("state", 16'(pdState), 16'h2);
    check("dll", 16'(dllOn), 16'h0);
    cmd(ddrrp_pkg::CMD_NOP, 1'b1, 2'h0, 13'h0000);
    check("state", 16'(pdState), 16'h0);
    cmd(ddrrp_pkg::CMD_MRS, 1'b1, 2'h0, 13'h0100); // loop reset
    check("mode pulses", 16'(modePulses), 16'h2);
    $display("power-down test done");
  endtask : t_power_down
  task t_self_illegal();
    // banks idle long past the precharge period
    cmd(ddrrp_pkg::CMD_REF, 1'b0, 2'h0, 13'h0000);
    check("state", 16'(pdState), 16'h4);
    cmd(ddrrp_pkg::CMD_NOP, 1'b1, 2'h0, 13'h0000);
    check("state", 16'(pdState), 16'h0);
    cmd(ddrrp_pkg::CMD_ACT, 1'b0, 2'h0, 13'h0000);
    check("illegal", 16'(illegalSeq), 16'h1);
    $display("self refresh test done");
  endtask : t_self_illegal
  initial begin
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    repeat (2) @(posedge clk);
    t_refresh_mode();
    t_power_down();
    t_self_illegal();
    end_sim();
  end
endmodule : testbench
